// File: core/als_defines.vh
`ifndef ALS_DEFINES_VH
`define ALS_DEFINES_VH

// Fixed bus address, seven bits
`define ALS_SLAVE_ADDR      7'h29
// Command register after power-up: shut-down
`define ALS_CMD_RESET       8'h80
// Command codes
`define ALS_CMD_ACTIVATE    8'h04
`define ALS_CMD_START       8'h08
`define ALS_CMD_STOP        8'h30
// Shut-down select bit within the command byte
`define ALS_CMD_SHUTDN_BIT  7
// Result layout
`define ALS_COUNT_W         15
`define ALS_VALID_BIT       15
`define ALS_RESULT_RESET    16'h0000

`endif

// File: core/als_light_counter.v
`timescale 1ns/1ps
`include "als_defines.vh"

module als_light_counter #(
    parameter WIDTH = `ALS_COUNT_W
) (
    input  wire             clk_i,
    input  wire             arst_n_i,
    input  wire             freq_i,
    input  wire             count_en_i,
    input  wire             clear_i,
    output reg  [WIDTH-1:0] count_o
);

    reg  freq_meta;
    reg  freq_sync;
    reg  freq_prev;
    wire freq_rise;

    ////////////////////////////////////////////////////////////////
    // Frequency pin crosses in through two flops before any use
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            freq_meta <= 1'b0;
            freq_sync <= 1'b0;
            freq_prev <= 1'b0;
        end
        else
        begin
            freq_meta <= freq_i;
            freq_sync <= freq_meta;
            freq_prev <= freq_sync;
        end
    end

    assign freq_rise = freq_sync & ~freq_prev;

    ////////////////////////////////////////////////////////////////
    // Pulse counter; holds at all ones rather than wrapping to dark
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            count_o <= {WIDTH{1'b0}};
        else if (clear_i)
            count_o <= {WIDTH{1'b0}};
        else if (count_en_i && freq_rise && !(&count_o))
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end

endmodule

// File: core/als_i2c_slave.v
`timescale 1ns/1ps
`include "als_defines.vh"

module als_i2c_slave (
    input  wire MCLK_I,
    input  wire ARST_N_I,
    input  wire SCL_I,
    input  wire SDA_I,
    output reg  SDA_O,
    output reg  SDA_OE_N_O,
    input  wire LIGHT_FREQ_I,
    input  wire INTEGRATION_WINDOW_I,
    output reg  SENSOR_ACTIVE_O,
    output reg  INTEGRATING_O,
    output reg  RESULT_VALID_FLAG_O
);

    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_WDAT = 7'h08;
    localparam [6:0] ST_WACK = 7'h10;
    localparam [6:0] ST_RDAT = 7'h20;
    localparam [6:0] ST_RACK = 7'h40;

    reg  [2:0]                scl_sync;
    reg  [2:0]                sda_sync;
    reg  [6:0]                state;
    reg  [2:0]                bit_cnt;
    reg  [7:0]                rx_shift;
    reg  [7:0]                tx_shift;
    reg                       read_dir;
    reg                       second_byte;
    reg  [15:0]               snapshot;
    reg  [7:0]                command_control;
    reg                       counter_clear;
    reg  [1:0]                window_sync;
    wire [7:0]                tx_first;
    wire [`ALS_COUNT_W-1:0]   light_count;
    wire [15:0]               light_count_result;
    wire [7:0]                rx_next;
    wire                      scl_rise;
    wire                      scl_fall;
    wire                      start_cond;
    wire                      stop_cond;

    // Byte to send: command echo in shut-down, else result LS then MS
    function [7:0] tx_byte;
        input       shut;
        input       second;
        input [7:0] cmd;
        input [15:0] res;
        begin
            if (shut)
                tx_byte = cmd;
            else if (second)
                tx_byte = res[15:8];
            else
                tx_byte = res[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus pins are asynchronous; bit 1 is the first trusted stage
    always @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end
        else
        begin
            scl_sync <= {scl_sync[1:0], SCL_I};
            sda_sync <= {sda_sync[1:0], SDA_I};
        end
    end

    assign scl_rise   = scl_sync[1] & ~scl_sync[2];
    assign scl_fall   = ~scl_sync[1] & scl_sync[2];
    assign start_cond = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    assign stop_cond  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
    assign rx_next    = {rx_shift[6:0], sda_sync[1]};

    // Valid flag over the held count; bus writes have no path here
    assign light_count_result = {RESULT_VALID_FLAG_O, light_count};

    // First read byte, formed once so its top bit can be taken apart
    assign tx_first = tx_byte(command_control[`ALS_CMD_SHUTDN_BIT], 1'b0,
                              command_control, snapshot);

    ////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state       <= ST_IDLE;
            bit_cnt     <= 3'h0;
            rx_shift    <= 8'h00;
            tx_shift    <= 8'hFF;
            read_dir    <= 1'b0;
            second_byte <= 1'b0;
            snapshot    <= `ALS_RESULT_RESET;
            SDA_OE_N_O  <= 1'b1;
            SDA_O       <= 1'b0;
        end
        else
        begin
            SDA_O <= 1'b0;                       // Open drain: only ever pulls low
            if (start_cond)
            begin
                // Start or repeated start always restarts address phase
                state      <= ST_ADDR;
                bit_cnt    <= 3'h0;
                SDA_OE_N_O <= 1'b1;
            end
            else if (stop_cond)
            begin
                state      <= ST_IDLE;
                SDA_OE_N_O <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                        SDA_OE_N_O <= 1'b1;
                    ST_ADDR:
                        if (scl_rise)
                        begin
                            rx_shift <= rx_next;
                            bit_cnt  <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                            begin
                                read_dir    <= sda_sync[1];
                                second_byte <= 1'b0;
                                snapshot    <= light_count_result;
                                // Foreign address: stay off the bus until next start
                                if (rx_shift[6:0] == `ALS_SLAVE_ADDR)
                                    state <= ST_AACK;
                                else
                                    state <= ST_IDLE;
                            end
                        end
                    ST_AACK:
                        if (scl_fall)
                        begin
                            if (SDA_OE_N_O)
                                SDA_OE_N_O <= 1'b0;
                            else if (read_dir)
                            begin
                                // First data bit goes out on the ack-ending fall
                                SDA_OE_N_O <= tx_first[7];
                                tx_shift   <= {tx_first[6:0], 1'b1};
                                bit_cnt    <= 3'h0;
                                state      <= ST_RDAT;
                            end
                            else
                            begin
                                SDA_OE_N_O <= 1'b1;
                                bit_cnt    <= 3'h0;
                                state      <= ST_WDAT;
                            end
                        end
                    ST_WDAT:
                        if (scl_rise)
                        begin
                            rx_shift <= rx_next;
                            bit_cnt  <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                                state <= ST_WACK;
                        end
                    ST_WACK:
                        if (scl_fall)
                        begin
                            if (SDA_OE_N_O)
                                SDA_OE_N_O <= 1'b0;
                            else
                            begin
                                // Send Byte carries one byte; extras get no ack
                                SDA_OE_N_O <= 1'b1;
                                state      <= ST_IDLE;
                            end
                        end
                    ST_RDAT:
                        if (scl_fall)
                        begin
                            SDA_OE_N_O <= tx_shift[7];
                            tx_shift   <= {tx_shift[6:0], 1'b1};
                        end
                        else if (scl_rise)
                        begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                                state <= ST_RACK;
                        end
                    ST_RACK:
                        if (scl_fall)
                            SDA_OE_N_O <= 1'b1;      // Hand data line to master
                        else if (scl_rise)
                        begin
                            // NACK ends the read; ack after word's end also ends it
                            if (sda_sync[1] || second_byte)
                                state <= ST_IDLE;
                            else
                            begin
                                second_byte <= 1'b1;
                                tx_shift    <= tx_byte(command_control[`ALS_CMD_SHUTDN_BIT],
                                                       1'b1, command_control, snapshot);
                                bit_cnt     <= 3'h0;
                                state       <= ST_RDAT;
                            end
                        end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command register and operating state, updated on the 8th data bit
    always @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            command_control     <= `ALS_CMD_RESET;
            SENSOR_ACTIVE_O     <= 1'b0;
            INTEGRATING_O       <= 1'b0;
            RESULT_VALID_FLAG_O <= 1'b0;
            counter_clear       <= 1'b0;
        end
        else
        begin
            counter_clear <= 1'b0;
            if (state == ST_WDAT && scl_rise && bit_cnt == 3'h7 && !start_cond && !stop_cond)
            begin
                command_control <= rx_next;
                if (rx_next[`ALS_CMD_SHUTDN_BIT])
                begin
                    // Shut-down freezes the result; only a restart or the asynchronous reset clears it
                    SENSOR_ACTIVE_O <= 1'b0;
                    INTEGRATING_O   <= 1'b0;
                end
                else if (rx_next == `ALS_CMD_ACTIVATE)
                    SENSOR_ACTIVE_O <= 1'b1;
                else if (rx_next == `ALS_CMD_START && SENSOR_ACTIVE_O)
                begin
                    counter_clear       <= 1'b1;
                    RESULT_VALID_FLAG_O <= 1'b0;
                    INTEGRATING_O       <= 1'b1;
                end
                else if (rx_next == `ALS_CMD_STOP && INTEGRATING_O)
                begin
                    INTEGRATING_O       <= 1'b0;
                    RESULT_VALID_FLAG_O <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Light counter; window pin gates counting only while integrating
    als_light_counter #(
        .WIDTH      (`ALS_COUNT_W)
    ) u_counter (
        .clk_i      (MCLK_I),
        .arst_n_i   (ARST_N_I),
        .freq_i     (LIGHT_FREQ_I),
        .count_en_i (INTEGRATING_O & SENSOR_ACTIVE_O & window_sync[1]),
        .clear_i    (counter_clear),
        .count_o    (light_count)
    );

    // Window pin is external; two flops before use
    always @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            window_sync <= 2'h0;
        else
            window_sync <= {window_sync[0], INTEGRATION_WINDOW_I};
    end

endmodule

// File: dv/als_i2c_slave_sva.sv
`timescale 1ns/1ps
module als_i2c_slave_sva (
    input wire MCLK_I,
    input wire ARST_N_I,
    input wire SCL_I,
    input wire SDA_I,
    input wire SDA_O,
    input wire SDA_OE_N_O,
    input wire LIGHT_FREQ_I,
    input wire INTEGRATION_WINDOW_I,
    input wire SENSOR_ACTIVE_O,
    input wire INTEGRATING_O,
    input wire RESULT_VALID_FLAG_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    //////////////////////////////
    // Drive level kept for most of one bus clock period
    sequence s_oe_hold;
        $stable(SDA_OE_N_O)[*5];
    endsequence
    // Stop command: integration ends with the flag raised
    sequence s_stop_done;
        !INTEGRATING_O ##0 RESULT_VALID_FLAG_O;
    endsequence
    //////////////////////////////
    AST_DRIVE_LOW: assert property (SDA_O == 1'b0)
        else $error("data drive value not low");
    AST_OE_SCL_LOW: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
        else $error("data enable moved while bus clock high");
    AST_OE_STANDS: assert property ($changed(SDA_OE_N_O) |=> s_oe_hold)
        else $error("data enable did not stand for a bit time");
    AST_ACT_BEFORE_INT: assert property ($rose(INTEGRATING_O) |-> SENSOR_ACTIVE_O)
        else $error("integration began while not active");
    AST_START_CLEARS: assert property ($rose(INTEGRATING_O) |-> !RESULT_VALID_FLAG_O)
        else $error("valid flag kept at start");
    AST_STOP_SETS: assert property ($fell(INTEGRATING_O) && SENSOR_ACTIVE_O |-> s_stop_done)
        else $error("stop left the valid flag low");
    AST_VALID_ON_STOP: assert property ($rose(RESULT_VALID_FLAG_O) |-> $fell(INTEGRATING_O))
        else $error("valid flag rose without a stop");
    AST_SHUTDOWN: assert property ($fell(SENSOR_ACTIVE_O) |->
        !INTEGRATING_O && $stable(RESULT_VALID_FLAG_O))
        else $error("shut-down did not stop integration or lost flag");
endmodule

bind als_i2c_slave als_i2c_slave_sva u_sva (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .LIGHT_FREQ_I(LIGHT_FREQ_I),
    .INTEGRATION_WINDOW_I(INTEGRATION_WINDOW_I), .SENSOR_ACTIVE_O(SENSOR_ACTIVE_O),
    .INTEGRATING_O(INTEGRATING_O), .RESULT_VALID_FLAG_O(RESULT_VALID_FLAG_O)
);

// File: dv/als_bus_master.sv
`timescale 1ns/1ps
module als_bus_master (
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_o
);
    // Idle bus: both lines released, clock stands still
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    //////////////////////////////
    // Start: data falls while clock high
    task start;
    begin
        sda_o = 1'b0;
        #100 scl_o = 1'b0;
        #100;
    end
    endtask
    // One bit: set while clock low, sampled mid-high
    task bit_x(input b, output r);
    begin
        sda_o = b;
        #100 scl_o = 1'b1;
        #100 r = sda_i;
        #100 scl_o = 1'b0;
        #100;
    end
    endtask
    // Byte MSB first, then the acknowledge slot
    task xfer(input [7:0] tx, input ack_i, output [7:0] rx, output ack_o);
        integer i;
        reg     b;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            bit_x(tx[i], b);
            rx = {rx[6:0], b};
        end
        bit_x(ack_i, ack_o);
    end
    endtask
    // Stop: data rises while clock high
    task stop;
    begin
        sda_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #200;
    end
    endtask
endmodule

// File: dv/tb_als_i2c_slave.sv
`timescale 1ns/1ps
module tb_als_i2c_slave;
    reg        mclk;
    reg        arst_n;
    reg        freq;
    reg        win;
    reg [15:0] rx;
    reg        ack_a;
    reg        ack_d;
    reg        ack_l;
    integer    failures;
    integer    n_tests;
    integer    i;
    wire       scl;
    wire       sda;
    wire       sda_m;
    wire       sda_o;
    wire       oe_n;
    wire       act;
    wire       integ;
    wire       valid;
    // Open-drain wire with pull-up
    assign sda = sda_m & (oe_n ? 1'b1 : sda_o);
    als_i2c_slave dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .LIGHT_FREQ_I(freq), .INTEGRATION_WINDOW_I(win),
        .SENSOR_ACTIVE_O(act), .INTEGRATING_O(integ), .RESULT_VALID_FLAG_O(valid));
    als_bus_master m (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    // 20 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    //////////////////////////////
    task chk(input [15:0] exp, input [15:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    end
    endtask
    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // Address byte then nb data bytes; reads collect LS byte first
    task txn(input [7:0] ab, input [7:0] d, input integer nb);
        integer k;
        reg [7:0] b;
        reg       a;
    begin
        @(negedge mclk);
        m.start;
        m.xfer(ab, 1'b1, b, ack_a);
        for (k = 0; k < nb; k = k + 1)
        begin
            m.xfer(ab[0] ? 8'hFF : d, ab[0] ? (k == nb - 1) : 1'b1, b, a);
            rx = {b, rx[15:8]};
            ack_l = a;
            if (k == 0)
                ack_d = a;
        end
        m.stop;
    end
    endtask
    // Photo pulses three cycles high in a six-cycle period, slow enough for the synchroniser
    task pulses(input integer n);
    begin
        repeat (n)
        begin
            repeat (3) @(negedge mclk);
            freq = 1'b1;
            repeat (3) @(negedge mclk);
            freq = 1'b0;
        end
    end
    endtask
    task do_reset;
    begin
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
    end
    endtask
    //////////////////////////////
    // Main sequence
    initial
    begin
        failures = 0;
        n_tests = 0;
        freq = 1'b0;
        win = 1'b0;
        rx = 16'h0000;
        do_reset;
        chk(16'h0000, {13'h0000, act, integ, valid});
        txn(8'h53, 8'h00, 1);
        chk(16'h8000, {rx[15:8], 7'h00, ack_a});
        chk(16'h0000, {15'h0000, sda_o});
        for (i = 0; i < 3; i = i + 1)
        begin
            txn(i == 0 ? 8'h50 : i == 1 ? 8'h56 : 8'hD3, 8'h04, 0);
            chk(16'h0001, {15'h0000, ack_a});
        end
        chk(16'h0000, {15'h0000, act});
        txn(8'h52, 8'hA5, 1);
        chk(16'h0000, {14'h0000, ack_a, ack_d});
        txn(8'h53, 8'h00, 2);
        chk(16'hA5A5, rx);
        txn(8'h52, 8'h08, 1);
        chk(16'h0000, {14'h0000, act, integ});
        txn(8'h52, 8'h04, 1);
        chk(16'h0002, {14'h0000, act, integ});
        txn(8'h52, 8'h08, 1);
        chk(16'h0006, {13'h0000, act, integ, valid});
        win = 1'b1;
        pulses(5);
        win = 1'b0;
        pulses(3);
        win = 1'b1;
        pulses(2);
        win = 1'b0;
        txn(8'h52, 8'h30, 1);
        chk(16'h0005, {13'h0000, act, integ, valid});
        txn(8'h53, 8'h00, 2);
        chk(16'h8007, rx);
        txn(8'h53, 8'h00, 1);
        chk(16'h0007, {8'h00, rx[15:8]});
        txn(8'h52, 8'h55, 2);
        chk(16'h0001, {15'h0000, ack_l});
        txn(8'h53, 8'h00, 2);
        chk(16'h8007, rx);
        txn(8'h52, 8'h08, 1);
        win = 1'b1;
        pulses(3);
        txn(8'h53, 8'h00, 2);
        chk(16'h0003, rx);
        txn(8'h52, 8'h30, 1);
        txn(8'h52, 8'hC3, 1);
        chk(16'h0001, {13'h0000, act, integ, valid});
        txn(8'h53, 8'h00, 1);
        chk(16'h00C3, {8'h00, rx[15:8]});
        do_reset;
        chk(16'h0000, {13'h0000, act, integ, valid});
        txn(8'h53, 8'h00, 1);
        chk(16'h0080, {8'h00, rx[15:8]});
        complete_run;
    end
    // Watchdog: run needs well under 0.5 ms of bus traffic
    initial
    begin
        #1000000;
        failures = failures + 1;
        complete_run;
    end
endmodule
